/* hw/nvac_core.sv */
/*
 * Nonvolatile data memory access controller: a 64-byte byte-wide store
 * reached only through three special function registers (address, data
 * and control/status), with one-cycle reads and self-timed
 * erase-then-program writes.
 * Assumes the core drives the register port on the same clock, that
 * the master-clear and watchdog reset requests are synchronous to it,
 * and that rst_b_i is the power-on reset, which clears every register but not the store.
 */

// Functional notes
// - The store holds 64 bytes at locations 00h to 3Fh, accessed one byte at a time.
// - The core can read and write the store at any time in normal operation.
// - The store is reached only through the address, data and control registers.
// - The data register carries the byte moved and the address register selects the location.
// - A byte write erases the location first and then programs the new byte.
// - An internal timer sets the write duration and hardware signals its end.
// - Code protection blocks the programmer port but never the core.
// - The address register is eight bits and a nonzero top pair falls outside the store.
// - The control register sits at data address 88h.
// - The done flag is set when a write ends and only software clears it.
// - The abort flag is set when a master-clear or watchdog reset cuts a write short.
// - The write gate bit allows writes when one and inhibits them when zero.
// - The write bit starts a write, is only set by software and cleared by hardware.
// - The read bit loads the data register in one cycle and then clears itself.
// - A finished write raises a wake request when its enable is set.
module nvac_core #(
    parameter int WRITE_NS = nvac_pkg::WRITE_TIME_NS,
    parameter int TW       = 16
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       master_clear_rst_i,
    input  wire logic       watchdog_rst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_we_i,
    input  wire logic       sfr_re_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       wake_enable_i,
    output logic            wake_o,
    input  wire logic       code_protect_i,
    input  wire logic [5:0] prog_addr_i,
    input  wire logic       prog_re_i,
    output logic      [7:0] prog_rdata_o,
    output logic            busy_o
);

    // Cycles per phase; the write duration is split evenly into erase and program.
    localparam int WRITE_CYC = (WRITE_NS * nvac_pkg::CLK_MHZ + 999) / 1000;
    localparam int PHASE_CYC = (WRITE_CYC / 2 < 1) ? 1 : WRITE_CYC / 2;
    localparam logic [TW-1:0] PHASE_LAST = TW'(PHASE_CYC - 1);

    function automatic logic in_store(input logic [7:0] a);
        in_store = (a[7:nvac_pkg::MEM_AW] == 2'b00);
    endfunction : in_store

    logic [7:0] mem [nvac_pkg::MEM_DEPTH];

    nvac_pkg::nvac_state_t state_reg, state_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic [7:0]    address_reg, address_next;
    logic [7:0]    data_reg, data_next;
    logic [7:0]    wr_data_reg, wr_data_next;
    logic [5:0]    wr_addr_reg, wr_addr_next;
    logic          read_reg, read_next;
    logic          write_reg, write_next;
    logic          gate_reg, gate_next;
    logic          abort_reg, abort_next;
    logic          done_reg, done_next;
    logic [7:0]    rdata_reg, rdata_next;
    logic [7:0]    prog_rdata_reg, prog_rdata_next;
    logic          mem_we;
    logic [7:0]    mem_wdata;
    logic          ctl_wr, core_rst, phase_end, start_write;
    logic [7:0]    ctl_value, mem_word;

    assign ctl_wr    = sfr_we_i && (sfr_addr_i == nvac_pkg::NV_CONTROL_ADDR);
    assign core_rst  = master_clear_rst_i || watchdog_rst_i;
    assign phase_end = (timer_reg == PHASE_LAST);
    assign mem_word  = mem[address_reg[5:0]];
    assign ctl_value = {3'b000, done_reg, abort_reg, gate_reg, write_reg, read_reg};
    assign start_write = ctl_wr && sfr_wdata_i[nvac_pkg::CTL_WRITE_BIT] && gate_reg
                         && (state_reg == nvac_pkg::NVAC_IDLE) && !core_rst
                         && in_store(address_reg);

    always_comb begin
        state_next      = state_reg;
        timer_next      = timer_reg;
        address_next    = address_reg;
        data_next       = data_reg;
        wr_data_next    = wr_data_reg;
        wr_addr_next    = wr_addr_reg;
        read_next       = 1'b0;
        write_next      = write_reg;
        gate_next       = gate_reg;
        abort_next      = abort_reg;
        done_next       = done_reg;
        mem_we          = 1'b0;
        mem_wdata       = nvac_pkg::ERASED_BYTE;
        rdata_next      = 8'h00;
        prog_rdata_next = 8'h00;

        // Register writes from the core.
        if (sfr_we_i && (sfr_addr_i == nvac_pkg::NV_ADDRESS_ADDR)) begin
            address_next = sfr_wdata_i;
        end
        if (sfr_we_i && (sfr_addr_i == nvac_pkg::NV_DATA_ADDR)) begin
            data_next = sfr_wdata_i;
        end
        if (ctl_wr) begin
            gate_next  = sfr_wdata_i[nvac_pkg::CTL_GATE_BIT];
            abort_next = sfr_wdata_i[nvac_pkg::CTL_ABORT_BIT];
            done_next  = sfr_wdata_i[nvac_pkg::CTL_DONE_BIT];
            read_next  = sfr_wdata_i[nvac_pkg::CTL_READ_BIT];
        end
        if (start_write) begin
            write_next   = 1'b1;
            wr_addr_next = address_reg[5:0];
            wr_data_next = data_reg;
            timer_next   = '0;
            state_next   = nvac_pkg::NVAC_ERASE;
        end

        // A read set in the previous cycle loads the data register now.
        if (read_reg) begin
            data_next = in_store(address_reg) ? mem_word : 8'h00;
        end

        case (state_reg)
            nvac_pkg::NVAC_IDLE: begin
            end
            nvac_pkg::NVAC_ERASE: begin
                timer_next = timer_reg + TW'(1);
                if (phase_end) begin
                    mem_we     = 1'b1;
                    mem_wdata  = nvac_pkg::ERASED_BYTE;
                    timer_next = '0;
                    state_next = nvac_pkg::NVAC_PROG;
                end
            end
            nvac_pkg::NVAC_PROG: begin
                timer_next = timer_reg + TW'(1);
                if (phase_end) begin
                    mem_we     = 1'b1;
                    mem_wdata  = wr_data_reg;
                    write_next = 1'b0;
                    done_next  = 1'b1;
                    state_next = nvac_pkg::NVAC_IDLE;
                end
            end
            default: begin
                state_next = nvac_pkg::NVAC_IDLE;
            end
        endcase

        // Master-clear or watchdog reset: abandon any write and flag the cut.
        if (core_rst) begin
            // A control write in this cycle is ignored, so the flag only keeps or sets.
            abort_next   = abort_reg || (state_reg != nvac_pkg::NVAC_IDLE);
            mem_we       = 1'b0;
            state_next   = nvac_pkg::NVAC_IDLE;
            timer_next   = '0;
            write_next   = 1'b0;
            read_next    = 1'b0;
            gate_next    = 1'b0;
            done_next    = done_reg;
        end

        if (sfr_re_i) begin
            case (sfr_addr_i)
                nvac_pkg::NV_DATA_ADDR:    rdata_next = data_reg;
                nvac_pkg::NV_ADDRESS_ADDR: rdata_next = address_reg;
                nvac_pkg::NV_CONTROL_ADDR: rdata_next = ctl_value;
                default:                   rdata_next = 8'h00;
            endcase
        end

        // The programmer sees zeros while code protection is on.
        if (prog_re_i && !code_protect_i) begin
            prog_rdata_next = mem[prog_addr_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg      <= nvac_pkg::NVAC_IDLE;
            timer_reg      <= '0;
            address_reg    <= nvac_pkg::ADDRESS_RESET;
            data_reg       <= nvac_pkg::DATA_RESET;
            wr_data_reg    <= nvac_pkg::DATA_RESET;
            wr_addr_reg    <= '0;
            read_reg       <= 1'b0;
            write_reg      <= 1'b0;
            gate_reg       <= 1'b0;
            abort_reg      <= 1'b0;
            done_reg       <= 1'b0;
            rdata_reg      <= 8'h00;
            prog_rdata_reg <= 8'h00;
        end else begin
            state_reg      <= state_next;
            timer_reg      <= timer_next;
            address_reg    <= address_next;
            data_reg       <= data_next;
            wr_data_reg    <= wr_data_next;
            wr_addr_reg    <= wr_addr_next;
            read_reg       <= read_next;
            write_reg      <= write_next;
            gate_reg       <= gate_next;
            abort_reg      <= abort_next;
            done_reg       <= done_next;
            rdata_reg      <= rdata_next;
            prog_rdata_reg <= prog_rdata_next;
        end
    end

    // The store keeps its contents through every reset.
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[wr_addr_reg] <= mem_wdata;
        end
    end

    assign sfr_rdata_o  = rdata_reg;
    assign prog_rdata_o = prog_rdata_reg;
    assign wake_o       = done_reg && wake_enable_i;
    assign busy_o       = write_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence seq_erase_end;
        (state_reg == nvac_pkg::NVAC_ERASE) && phase_end && !core_rst;
    endsequence
    sequence seq_prog_end;
        (state_reg == nvac_pkg::NVAC_PROG) && phase_end && !core_rst;
    endsequence

    chk_read_selfclear: assert property ((read_reg
        && !(ctl_wr && sfr_wdata_i[nvac_pkg::CTL_READ_BIT])) |=> !read_reg)
        else $error("read bit did not clear itself");
    chk_read_loads: assert property ((read_reg && in_store(address_reg))
        |=> data_reg == $past(mem_word))
        else $error("read did not load the data register");
    chk_gate_blocks: assert property ((ctl_wr && !gate_reg
        && state_reg == nvac_pkg::NVAC_IDLE) |=> state_reg == nvac_pkg::NVAC_IDLE)
        else $error("write started with gate bit clear");
    chk_erase_first: assert property (seq_erase_end
        |=> state_reg == nvac_pkg::NVAC_PROG && mem[wr_addr_reg] == nvac_pkg::ERASED_BYTE)
        else $error("location not erased before programming");
    chk_write_ends: assert property (seq_prog_end
        |=> done_reg && !write_reg && mem[wr_addr_reg] == $past(wr_data_reg))
        else $error("write end not signalled correctly");
    chk_timer_bound: assert property (state_reg != nvac_pkg::NVAC_IDLE
        |-> timer_reg <= PHASE_LAST)
        else $error("write timer ran past its phase");
    chk_abort_flag: assert property ((core_rst && state_reg != nvac_pkg::NVAC_IDLE)
        |=> abort_reg && !write_reg)
        else $error("cut write not flagged");
    chk_done_sticky: assert property ((done_reg && !ctl_wr) |=> done_reg)
        else $error("done flag cleared by hardware");
    chk_ctl_top_zero: assert property ((sfr_re_i && sfr_addr_i == nvac_pkg::NV_CONTROL_ADDR)
        |=> sfr_rdata_o[7:5] == 3'b000)
        else $error("unused control bits read nonzero");
    chk_protect_blocks: assert property ((prog_re_i && code_protect_i)
        |=> prog_rdata_o == 8'h00)
        else $error("programmer read while protected");

endmodule : nvac_core

/* hw/nvac_pkg.sv */
/*
 * Constants shared by the nonvolatile data memory access controller:
 * special function register addresses, control bit positions, reset
 * values and memory geometry.
 * Assumes a single 250 MHz core clock; times are given in nanoseconds.
 */
package nvac_pkg;

    // Special function register addresses on the core data bus.
    localparam logic [7:0] NV_DATA_ADDR     = 8'h08;
    localparam logic [7:0] NV_ADDRESS_ADDR  = 8'h09;
    localparam logic [7:0] NV_CONTROL_ADDR  = 8'h88;
    localparam logic [7:0] NV_SEQUENCE_ADDR = 8'h89;

    // Control and status bit positions.
    localparam int CTL_READ_BIT  = 0;
    localparam int CTL_WRITE_BIT = 1;
    localparam int CTL_GATE_BIT  = 2;
    localparam int CTL_ABORT_BIT = 3;
    localparam int CTL_DONE_BIT  = 4;

    // Reset values and the erased byte value.
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] ADDRESS_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;

    // Memory geometry: 64 bytes, six implemented address bits.
    localparam int MEM_DEPTH  = 64;
    localparam int MEM_AW     = 6;

    // Core clock and default self-timed write duration.
    localparam int CLK_MHZ       = 250;
    localparam int WRITE_TIME_NS = 10000;

    typedef enum logic [2:0] {
        NVAC_IDLE  = 3'b001,
        NVAC_ERASE = 3'b010,
        NVAC_PROG  = 3'b100
    } nvac_state_t;

endpackage : nvac_pkg

/* dv/nvac_core_tb.sv */
/*
 * Self-checking bench for the nonvolatile data memory access controller.
 * It drives the register port, the core reset requests and the programmer port.
 * It assumes nvac_pkg and nvac_core are compiled first.
 * The write time is shortened to 40 ns, which gives five cycles per phase.
 */
module nvac_core_tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        string      nm;
        logic [7:0] v;
    } nvac_exp_t;

    localparam logic [7:0] A_CTL = nvac_pkg::NV_CONTROL_ADDR;
    localparam logic [7:0] A_DAT = nvac_pkg::NV_DATA_ADDR;
    localparam logic [7:0] A_ADR = nvac_pkg::NV_ADDRESS_ADDR;
    localparam logic [7:0] A_SEQ = nvac_pkg::NV_SEQUENCE_ADDR;

    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        mc = 1'b0;
    logic        wd = 1'b0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        wake_en = 1'b1;
    logic        cp = 1'b0;
    logic        prog_re = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [5:0]  prog_addr = 6'h00;
    logic        rd_q = 1'b0;
    logic        pr_q = 1'b0;
    logic [31:0] seed = 32'h0000005e;
    logic [7:0]  ra;
    logic [7:0]  rdat;
    wire  [7:0]  rdata;
    wire  [7:0]  prog_rdata;
    wire         wake;
    wire         busy;
    int          n_errors = 0;
    int          checks = 0;
    nvac_exp_t   expq[$];

    always #2 clk_i = ~clk_i;

    nvac_core #(.WRITE_NS(40)) u_dut (
        .clk_i              (clk_i),
        .rst_b_i            (rst_b_i),
        .master_clear_rst_i (mc),
        .watchdog_rst_i     (wd),
        .sfr_addr_i         (addr),
        .sfr_wdata_i        (wdata),
        .sfr_we_i           (we),
        .sfr_re_i           (re),
        .sfr_rdata_o        (rdata),
        .wake_enable_i      (wake_en),
        .wake_o             (wake),
        .code_protect_i     (cp),
        .prog_addr_i        (prog_addr),
        .prog_re_i          (prog_re),
        .prog_rdata_o       (prog_rdata),
        .busy_o             (busy)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic conclude;
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic cyc;
        @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        cyc();
        we = 1'b0;
        cyc();
    endtask : wr

    // Notes the expected byte, then issues the read; the monitor compares it.
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        expq.push_back('{nm, e});
        addr = a;
        re = 1'b1;
        cyc();
        re = 1'b0;
        cyc();
    endtask : rd

    task automatic prd(input string nm, input logic [5:0] a, input logic [7:0] e);
        expq.push_back('{nm, e});
        prog_addr = a;
        prog_re = 1'b1;
        cyc();
        prog_re = 1'b0;
        cyc();
    endtask : prd

    task automatic wait_idle;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) cyc();
        if (busy !== 1'b0) begin
            chk("busy_timeout", 8'h00, {7'h00, busy});
            conclude();
        end
    endtask : wait_idle

    task automatic nvwrite(input logic [7:0] a, input logic [7:0] d);
        wr(A_ADR, a);
        wr(A_DAT, d);
        wr(A_CTL, 8'h04);
        wr(A_CTL, 8'h06);
        chk("busy_start", 8'h01, {7'h00, busy});
        wait_idle();
    endtask : nvwrite

    task automatic nvread(input string nm, input logic [7:0] a, input logic [7:0] e);
        wr(A_ADR, a);
        wr(A_CTL, 8'h05);
        rd(nm, A_DAT, e);
    endtask : nvread

    always @(posedge clk_i) begin
        rd_q <= re;
        pr_q <= prog_re;
    end

    // Results are settled by the falling edge after the taking edge.
    always @(negedge clk_i) begin : monitor
        nvac_exp_t x;
        if (rd_q || pr_q) begin
            if (expq.size() == 0) begin
                chk("unexpected_result", 8'h00, 8'hxx);
            end else begin
                x = expq.pop_front();
                chk(x.nm, x.v, rd_q ? rdata : prog_rdata);
            end
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        rd("ctl_reset", A_CTL, 8'h00);
        rd("addr_reset", A_ADR, 8'h00);
        nvwrite(8'h3f, 8'h5a);
        rd("ctl_done", A_CTL, 8'h14);
        chk("wake_set", 8'h01, {7'h00, wake});
        wake_en = 1'b0;
        cyc();
        chk("wake_masked", 8'h00, {7'h00, wake});
        wake_en = 1'b1;
        wr(A_CTL, 8'h04);
        chk("wake_clr", 8'h00, {7'h00, wake});
        nvread("top_loc", 8'h3f, 8'h5a);
        rd("ctl_rd_clr", A_CTL, 8'h04);
        wr(A_CTL, 8'he4);
        rd("ctl_unused", A_CTL, 8'h04);
        rd("seq_reg", A_SEQ, 8'h00);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            ra = {2'b00, seed[5:0]};
            rdat = seed[15:8];
            nvwrite(ra, rdat);
            nvread("rand_loc", ra, rdat);
            prd("prog_open", ra[5:0], rdat);
        end
        cp = 1'b1;
        prd("prog_prot", ra[5:0], 8'h00);
        nvread("core_prot", ra, rdat);
        cp = 1'b0;
        wr(A_CTL, 8'h00);
        wr(A_CTL, 8'h02);
        chk("gated_busy", 8'h00, {7'h00, busy});
        nvread("gated_keep", ra, rdat);
        wr(A_ADR, 8'h40);
        wr(A_CTL, 8'h05);
        rd("out_range", A_DAT, 8'h00);
        wr(A_CTL, 8'h06);
        chk("range_busy", 8'h00, {7'h00, busy});
        wr(A_ADR, ra);
        wr(A_DAT, ~rdat);
        wr(A_CTL, 8'h04);
        wr(A_CTL, 8'h06);
        wr(A_CTL, 8'h04);
        chk("wr_no_clear", 8'h01, {7'h00, busy});
        wait_idle();
        nvread("rewrite", ra, ~rdat);
        for (int s = 0; s < 2; s++) begin
            wr(A_CTL, 8'h04);
            wr(A_CTL, 8'h06);
            if (s == 0) mc = 1'b1;
            else wd = 1'b1;
            cyc();
            mc = 1'b0;
            wd = 1'b0;
            cyc();
            chk("abort_busy", 8'h00, {7'h00, busy});
            rd("ctl_abort", A_CTL, 8'h08);
        end
        // A power-on reset in mid-run clears every flag but keeps the store.
        rst_b_i = 1'b0;
        repeat (2) cyc();
        rst_b_i = 1'b1;
        rd("ctl_por", A_CTL, 8'h00);
        nvread("kept_por", ra, ~rdat);
        conclude();
    end

    initial begin
        #100000;
        chk("run_timeout", 8'h00, 8'h01);
        conclude();
    end
endmodule : nvac_core_tb
